// [verilog/dmc_pkg.sv]
// Constants and types shared by the direct mode command control block
package dmc_pkg;

  // ==========================================================
  // Word layout
  localparam int          BYTE_W     = 8;
  localparam int          ADDR_W     = 5;
  localparam int          BIT_CMD    = 7;
  localparam int          BIT_RD     = 6;
  localparam int          BIT_CONT   = 5;
  localparam int          BIT_DIRECT = 6;

  // ==========================================================
  // Register offsets
  localparam logic [4:0]  ADR_CSC    = 5'h00;
  localparam logic [4:0]  ADR_PROT   = 5'h01;
  localparam logic [4:0]  ADR_MODC   = 5'h09;
  localparam logic [4:0]  ADR_COLL   = 5'h0e;
  localparam logic [4:0]  ADR_FSTAT  = 5'h1c;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  CSC_RST    = 8'h00;
  localparam logic [7:0]  PROT_RST   = 8'h02;
  localparam logic [7:0]  MODC_RST   = 8'h00;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  // ==========================================================
  // Command codes
  localparam logic [4:0]  CMD_IDLE   = 5'h00;
  localparam logic [4:0]  CMD_INIT   = 5'h03;
  localparam logic [4:0]  CMD_RESET  = 5'h0f;
  localparam logic [4:0]  CMD_TX     = 5'h10;
  localparam logic [4:0]  CMD_TXCRC  = 5'h11;
  localparam logic [4:0]  CMD_SLOT   = 5'h14;
  localparam logic [4:0]  CMD_RXBLK  = 5'h16;
  localparam logic [4:0]  CMD_RXEN   = 5'h17;
  localparam logic [4:0]  CMD_RSSI1  = 5'h18;
  localparam logic [4:0]  CMD_RSSI0  = 5'h19;
  localparam logic [4:0]  CMD_GAIN   = 5'h1a;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } dmc_phase_type;

endpackage

// [verilog/dmc_sync.sv]
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module dmc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // Levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dmc_sync_type;

  dmc_sync_type s_r;
  dmc_sync_type s_nxt;

  if (W < 1) begin : g_chk
    $error("dmc_sync width below one");
  end

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= {INIT, INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.s2;

endmodule

// [verilog/dmc_spi_link.sv]
// Serial link shifter on the host clock, mode 0, MSB first
`timescale 1ns/1ps
module dmc_spi_link
  import dmc_pkg::*;
(
  // Link clock and resets
  input  wire logic              sclk_in,
  input  wire logic              ss_n_in,
  input  wire logic              resetn_in,
  // Serial pins
  input  wire logic              mosi_in,
  output logic                   miso_out,
  // Core side
  input  wire logic [BYTE_W-1:0] rdata_in,
  output logic      [BYTE_W-1:0] rx_byte_out,
  output logic                   byte_tog_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]        cnt;
    logic [BYTE_W-2:0] sr;
  } dmc_link_type;

  dmc_link_type l_r;
  dmc_link_type l_nxt;
  logic [BYTE_W-2:0] msr_r;

  always_comb begin
    l_nxt     = l_r;
    l_nxt.cnt = l_r.cnt + 3'h1;
    l_nxt.sr  = {l_r.sr[BYTE_W-3:0], mosi_in};
  end

  // Bit counter clears while slave select is high
  always_ff @(posedge sclk_in or posedge ss_n_in or negedge resetn_in) begin
    if (!resetn_in) begin
      l_r <= '0;
    end else if (ss_n_in) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // Toggle survives slave select so the core never sees a false byte
  always_ff @(posedge sclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_byte_out  <= ZERO_BYTE;
      byte_tog_out <= 1'b0;
    end else if (!ss_n_in && l_r.cnt == 3'h7) begin
      rx_byte_out  <= {l_r.sr, mosi_in};
      byte_tog_out <= ~byte_tog_out;
    end
  end

  // Read data leaves on falling edges; rdata_in is quasi-static
  always_ff @(negedge sclk_in or posedge ss_n_in or negedge resetn_in) begin
    if (!resetn_in) begin
      miso_out <= 1'b0;
      msr_r    <= '0;
    end else if (ss_n_in) begin
      miso_out <= 1'b0;
      msr_r    <= '0;
    end else if (l_r.cnt == 3'h0) begin
      miso_out <= rdata_in[BYTE_W-1];
      msr_r    <= rdata_in[BYTE_W-2:0];
    end else begin
      miso_out <= msr_r[BYTE_W-2];
      msr_r    <= {msr_r[BYTE_W-3:0], 1'b0};
    end
  end

endmodule

// [verilog/dmc_core.sv]
// Command decoder, register file and direct mode control
`timescale 1ns/1ps
module dmc_core
  import dmc_pkg::*;
#(
  parameter int REG_W = 8
) (
  // Clocks and reset
  input  wire logic             ref_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             sclk_in,
  // Serial port
  input  wire logic             ss_n_in,
  input  wire logic             mosi_in,
  output logic                  miso_out,
  // Direct mode pins
  input  wire logic             modulation_input_in,
  input  wire logic             subcarrier_in,
  output logic                  rf_mod_out,
  output logic                  rx_data_out,
  output logic                  direct_active_out,
  // Framer side
  input  wire logic             decoded_data_in,
  input  wire logic             irq_req_in,
  input  wire logic             tx_done_in,
  input  wire logic             fifo_we_in,
  input  wire logic [REG_W-1:0] fifo_level_in,
  input  wire logic             coll_we_in,
  input  wire logic [REG_W-1:0] coll_pos_in,
  output logic                  irq_out,
  output logic                  fifo_enable_out,
  output logic                  fifo_clear_out,
  // Command strobes and receiver block level
  output logic                  tx_start_out,
  output logic                  tx_crc_out,
  output logic                  next_slot_out,
  output logic                  rx_block_out,
  output logic                  rssi_tx_on_out,
  output logic                  rssi_tx_off_out,
  output logic                  gain_adjust_out,
  output logic                  soft_init_out,
  // Register views
  output logic      [REG_W-1:0] chip_status_out,
  output logic      [REG_W-1:0] protocol_out,
  output logic      [REG_W-1:0] modulator_out
);

  // ==========================================================
  // Elaboration check
  if (REG_W != BYTE_W) begin : g_chk
    $error("dmc_core registers must be one byte wide");
  end

  // ==========================================================
  // State
  typedef struct packed {
    dmc_phase_type    ph;
    logic [4:0]       addr;
    logic             cont;
    logic [REG_W-1:0] csc;
    logic [REG_W-1:0] prot;
    logic [REG_W-1:0] modc;
    logic [REG_W-1:0] coll;
    logic [REG_W-1:0] fstat;
    logic [REG_W-1:0] rdata;
    logic             direct;
    logic             rxblk;
    logic             tog_d;
    logic             ss_d;
    logic             tx_go;
    logic             tx_crc;
    logic             slot;
    logic             rssi1;
    logic             rssi0;
    logic             gain;
    logic             fclr;
    logic             sinit;
    logic             rfmod;
    logic             rxd;
    logic             irq;
    logic             fen;
  } dmc_state_type;

  dmc_state_type s_r;
  dmc_state_type s_nxt;

  // ==========================================================
  // Link and pin crossing
  logic [BYTE_W-1:0] rx_byte;
  logic              byte_tog;
  logic [3:0]        sync_q;
  logic              ss_s;
  logic              tog_s;
  logic              mod_s;
  logic              sub_s;

  dmc_spi_link u_link (
    .sclk_in      (sclk_in),
    .ss_n_in      (ss_n_in),
    .resetn_in    (resetn_in),
    .mosi_in      (mosi_in),
    .miso_out     (miso_out),
    .rdata_in     (s_r.rdata),
    .rx_byte_out  (rx_byte),
    .byte_tog_out (byte_tog)
  );

  // Slave select idles high, so its stages start high
  dmc_sync #(
    .W    (4),
    .INIT (4'h8)
  ) u_sync (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .d_in      ({ss_n_in, byte_tog, modulation_input_in, subcarrier_in}),
    .q_out     (sync_q)
  );

  assign ss_s  = sync_q[3];
  assign tog_s = sync_q[2];
  assign mod_s = sync_q[1];
  assign sub_s = sync_q[0];

  // ==========================================================
  // Decode helpers
  logic byte_ev;
  logic stop_ev;
  logic refuse;
  logic cmd_ev;

  assign byte_ev = tog_s != s_r.tog_d;
  assign stop_ev = ss_s && !s_r.ss_d;
  assign refuse  = s_r.direct && !s_r.prot[BIT_DIRECT];
  assign cmd_ev  = byte_ev && !refuse && s_r.ph == PH_IDLE
                   && rx_byte[BIT_CMD];

  function automatic dmc_state_type rst_state();
    dmc_state_type r;
    r      = '0;
    r.ph   = PH_IDLE;
    r.csc  = CSC_RST;
    r.prot = PROT_RST;
    r.modc = MODC_RST;
    r.fen  = 1'b1;
    r.ss_d = 1'b1;
    return r;
  endfunction

  // Unmapped offsets read as zero
  function automatic logic [REG_W-1:0] rd_reg(input logic [4:0]    a,
                                              input dmc_state_type s);
    logic [REG_W-1:0] v;
    v = ZERO_BYTE;
    case (a)
      ADR_CSC:   v = s.csc;
      ADR_PROT:  v = s.prot;
      ADR_MODC:  v = s.modc;
      ADR_COLL:  v = s.coll;
      ADR_FSTAT: v = s.fstat;
      default:   v = ZERO_BYTE;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [4:0] a1;
    a1             = s_r.addr + 5'h01;
    s_nxt          = s_r;
    s_nxt.tog_d    = tog_s;
    s_nxt.ss_d     = ss_s;
    s_nxt.tx_go    = 1'b0;
    s_nxt.tx_crc   = 1'b0;
    s_nxt.slot     = 1'b0;
    s_nxt.rssi1    = 1'b0;
    s_nxt.rssi0    = 1'b0;
    s_nxt.gain     = 1'b0;
    s_nxt.fclr     = 1'b0;
    s_nxt.sinit    = 1'b0;
    if (fifo_we_in) begin
      s_nxt.fstat = fifo_level_in;
    end
    if (coll_we_in) begin
      s_nxt.coll = coll_pos_in;
    end
    if (tx_done_in) begin
      s_nxt.rxblk = 1'b0;
    end
    if (byte_ev && !refuse) begin
      unique case (s_r.ph)
        PH_IDLE: begin
          if (rx_byte[BIT_CMD]) begin
            case (rx_byte[ADDR_W-1:0])
              CMD_INIT: begin
                s_nxt       = rst_state();
                s_nxt.tog_d = tog_s;
                s_nxt.ss_d  = ss_s;
                s_nxt.sinit = 1'b1;
              end
              CMD_RESET: begin
                s_nxt.fclr  = 1'b1;
                s_nxt.fstat = ZERO_BYTE;
                s_nxt.coll  = ZERO_BYTE;
              end
              CMD_TX: s_nxt.tx_go = 1'b1;
              CMD_TXCRC: begin
                s_nxt.tx_go  = 1'b1;
                s_nxt.tx_crc = 1'b1;
              end
              CMD_SLOT:  s_nxt.slot  = 1'b1;
              CMD_RXBLK: s_nxt.rxblk = 1'b1;
              CMD_RXEN:  s_nxt.rxblk = 1'b0;
              CMD_RSSI1: s_nxt.rssi1 = 1'b1;
              CMD_RSSI0: s_nxt.rssi0 = 1'b1;
              CMD_GAIN:  s_nxt.gain  = 1'b1;
              default:   s_nxt.gain  = 1'b0;
            endcase
          end else begin
            s_nxt.addr = rx_byte[ADDR_W-1:0];
            s_nxt.cont = rx_byte[BIT_CONT];
            if (rx_byte[BIT_RD]) begin
              s_nxt.ph    = PH_READ;
              s_nxt.rdata = rd_reg(rx_byte[ADDR_W-1:0], s_r);
            end else begin
              s_nxt.ph = PH_WRITE;
            end
          end
        end
        PH_WRITE: begin
          case (s_r.addr)
            ADR_CSC: begin
              s_nxt.csc    = rx_byte;
              s_nxt.direct = rx_byte[BIT_DIRECT];
            end
            ADR_PROT: s_nxt.prot = rx_byte;
            ADR_MODC: s_nxt.modc = rx_byte;
            default:  s_nxt.modc = s_r.modc;
          endcase
          if (s_r.cont) begin
            s_nxt.addr = a1;
          end else begin
            s_nxt.ph = PH_IDLE;
          end
        end
        PH_READ: begin
          if (s_r.cont) begin
            s_nxt.addr  = a1;
            s_nxt.rdata = rd_reg(a1, s_r);
          end else begin
            s_nxt.ph = PH_IDLE;
          end
        end
      endcase
    end
    // A stop outranks the byte that ends with it
    if (stop_ev) begin
      s_nxt.direct          = 1'b0;
      s_nxt.csc[BIT_DIRECT] = 1'b0;
      s_nxt.ph              = PH_IDLE;
    end
    s_nxt.rfmod = s_r.direct && mod_s;
    s_nxt.rxd   = s_r.direct && (s_r.prot[BIT_DIRECT] ? decoded_data_in
                                                      : sub_s);
    s_nxt.irq   = irq_req_in && !s_r.direct;
    s_nxt.fen   = !s_r.direct;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= rst_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rf_mod_out        = s_r.rfmod;
  assign rx_data_out       = s_r.rxd;
  assign direct_active_out = s_r.direct;
  assign irq_out           = s_r.irq;
  assign fifo_enable_out   = s_r.fen;
  assign fifo_clear_out    = s_r.fclr;
  assign tx_start_out      = s_r.tx_go;
  assign tx_crc_out        = s_r.tx_crc;
  assign next_slot_out     = s_r.slot;
  assign rx_block_out      = s_r.rxblk;
  assign rssi_tx_on_out    = s_r.rssi1;
  assign rssi_tx_off_out   = s_r.rssi0;
  assign gain_adjust_out   = s_r.gain;
  assign soft_init_out     = s_r.sinit;
  assign chip_status_out   = s_r.csc;
  assign protocol_out      = s_r.prot;
  assign modulator_out     = s_r.modc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  a_enter_direct: assert property (
    byte_ev && !refuse && !stop_ev && s_r.ph == PH_WRITE
    && s_r.addr == ADR_CSC && rx_byte[BIT_DIRECT] |=> s_r.direct)
    else $error("direct mode not entered");
  a_stop_clears: assert property (
    stop_ev |=> !s_r.direct && !s_r.csc[BIT_DIRECT] ##1 !direct_active_out)
    else $error("stop did not end direct mode");
  a_refuse_access: assert property (
    byte_ev && refuse && !stop_ev
    |=> $stable(s_r.prot) && $stable(s_r.modc) && $stable(s_r.ph))
    else $error("register access taken in raw direct mode");
  a_mod_follows: assert property (
    s_r.direct |=> rf_mod_out == $past(mod_s))
    else $error("modulation output does not follow pin");
  a_no_irq_direct: assert property (
    s_r.direct |=> !irq_out && !fifo_enable_out)
    else $error("interrupt or FIFO active in direct mode");
  a_raw_rx: assert property (
    s_r.direct && !s_r.prot[BIT_DIRECT] |=> rx_data_out == $past(sub_s))
    else $error("raw subcarrier not presented");
  a_soft_init: assert property (
    cmd_ev && rx_byte[4:0] == CMD_INIT
    |=> soft_init_out && s_r.prot == PROT_RST && !s_r.direct
    ##1 !soft_init_out)
    else $error("software init did not reset state");
  a_fifo_reset: assert property (
    cmd_ev && rx_byte[4:0] == CMD_RESET && !fifo_we_in && !coll_we_in
    |=> fifo_clear_out && s_r.fstat == ZERO_BYTE && s_r.coll == ZERO_BYTE)
    else $error("reset command did not clear FIFO state");
  a_rx_block: assert property (
    cmd_ev && rx_byte[4:0] == CMD_RXBLK |=> rx_block_out)
    else $error("receiver not blocked");
  a_rx_enable: assert property (
    cmd_ev && rx_byte[4:0] == CMD_RXEN |=> !rx_block_out)
    else $error("receiver not released");
  a_rssi_pulse: assert property (
    cmd_ev && rx_byte[4:0] == CMD_RSSI1
    |=> rssi_tx_on_out ##1 !rssi_tx_on_out)
    else $error("signal strength strobe wrong");

endmodule

// [tb/dmc_host_model.sv]
// Host side serial master model for the command link, mode 0
`timescale 1ns/1ps
module dmc_host_model (
  // Serial pins
  output logic      sclk_out,
  output logic      ss_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  localparam time HALF = 80ns;

  initial begin
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // ==========================================================
  // Frame control
  // Odd lead-in keeps link edges off the system clock edges
  task automatic open_frame();
    #(4.7ns) ss_n_out = 1'b0;
    #(HALF);
  endtask

  // Raising select is the stop, so entry frames stay open
  task automatic close_frame();
    #(HALF) ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #(2 * HALF);
  endtask

  // ==========================================================
  // Byte transfer, clock stands low between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      #(HALF) rx[i] = miso_in;
      sclk_out = 1'b1;
      #(HALF) sclk_out = 1'b0;
    end
  endtask
endmodule

// [tb/direct_mode_command_control_tb.sv]
// Self-checking bench for the direct mode command control block
`timescale 1ns/1ps
module direct_mode_command_control_tb;
  import dmc_pkg::*;

  // ==========================================================
  // Signals
  logic       ref_clk_in = 1'b0;
  logic       resetn_in  = 1'b0;
  logic       sclk, ss_n, mosi, miso;
  logic       mod_pin = 1'b0, sub_pin = 1'b0, irq_req = 1'b0;
  logic       dec_pin = 1'b0, clr_seen = 1'b0;
  logic       tx_done = 1'b0, fifo_we = 1'b0, coll_we = 1'b0;
  logic [7:0] fifo_lvl = 8'h00, coll_pos = 8'h00;
  logic       rf_mod, rx_data, dir_act, irq, fifo_en, fifo_clr;
  logic       tx_st, tx_crc, slot, rx_blk, rs_on, rs_off, gain, sinit;
  logic [7:0] csc, prot, modc, rd, got;
  logic [7:0] seen = 8'h00;
  int         n_errors    = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  typedef struct {
    logic [4:0] code;
    logic [7:0] strobes;
  } dmc_row_type;
  // Strobe order: start, crc, slot, rssi on, rssi off, gain, init, clear
  dmc_row_type rows [9] = '{'{CMD_IDLE, 8'h00}, '{CMD_INIT, 8'h02},
    '{CMD_RESET, 8'h01}, '{CMD_TX, 8'h80}, '{CMD_TXCRC, 8'hc0},
    '{CMD_SLOT, 8'h20}, '{CMD_RSSI1, 8'h10}, '{CMD_RSSI0, 8'h08},
    '{CMD_GAIN, 8'h04}};

  always #5 ref_clk_in = ~ref_clk_in;

  dmc_host_model host (.sclk_out(sclk), .ss_n_out(ss_n),
    .mosi_out(mosi), .miso_in(miso));

  dmc_core dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .sclk_in(sclk), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
    .modulation_input_in(mod_pin), .subcarrier_in(sub_pin),
    .rf_mod_out(rf_mod), .rx_data_out(rx_data),
    .direct_active_out(dir_act), .decoded_data_in(dec_pin),
    .irq_req_in(irq_req), .tx_done_in(tx_done), .fifo_we_in(fifo_we),
    .fifo_level_in(fifo_lvl), .coll_we_in(coll_we),
    .coll_pos_in(coll_pos), .irq_out(irq), .fifo_enable_out(fifo_en),
    .fifo_clear_out(fifo_clr), .tx_start_out(tx_st),
    .tx_crc_out(tx_crc), .next_slot_out(slot), .rx_block_out(rx_blk),
    .rssi_tx_on_out(rs_on), .rssi_tx_off_out(rs_off),
    .gain_adjust_out(gain), .soft_init_out(sinit),
    .chip_status_out(csc), .protocol_out(prot), .modulator_out(modc));

  // Strobes last one cycle, so they are gathered as they pass
  always @(posedge ref_clk_in) begin
    if (clr_seen) begin
      seen <= 8'h00;
    end else begin
      seen <= seen | {tx_st, tx_crc, slot, rs_on, rs_off, gain, sinit,
                      fifo_clr};
    end
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, got_v);
    comparisons++;
    if (got_v !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got_v);
    end
  endtask

  task automatic chk1(input string what, input logic exp, got_v);
    comparisons++;
    if (got_v !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got_v);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.open_frame();
    host.xfer({3'b000, a}, rd);
    host.xfer(d, rd);
    host.close_frame();
    cyc(8);
  endtask

  task automatic rdr(input logic [4:0] a, output logic [7:0] d);
    host.open_frame();
    host.xfer({3'b010, a}, rd);
    host.xfer(8'h00, d);
    host.close_frame();
    cyc(2);
  endtask

  task automatic cmd(input logic [4:0] c);
    clr_seen = 1'b1;
    cyc(1);
    clr_seen = 1'b0;
    host.open_frame();
    host.xfer({3'b100, c}, rd);
    host.close_frame();
    cyc(8);
  endtask

  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    cyc(3);
    resetn_in = 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      cmd(rows[i].code);
      chk8("strobes", rows[i].strobes, seen);
    end
    // Second reset in mid-run
    wr(ADR_MODC, 8'h61);
    resetn_in = 1'b0;
    cyc(3);
    chk8("modulator", MODC_RST, modc);
    resetn_in = 1'b1;
    cyc(4);
    chk8("chip status", CSC_RST, csc);
    chk8("protocol", PROT_RST, prot);
    chk1("fifo enable", 1'b1, fifo_en);
    chk1("direct", 1'b0, dir_act);
    // Configuration and continuous read across an unmapped place
    wr(ADR_PROT, 8'h02);
    wr(ADR_MODC, 8'h61);
    chk8("modulator", 8'h61, modc);
    wr(5'h02, 8'haa);
    host.open_frame();
    host.xfer(8'h60, rd);
    host.xfer(8'h00, got);
    chk8("read 00", CSC_RST, got);
    host.xfer(8'h00, got);
    chk8("read 01", 8'h02, got);
    host.xfer(8'h00, got);
    chk8("read 02", ZERO_BYTE, got);
    host.close_frame();
    cyc(1);
    // Status loads, read-only refusal, then clear by command
    fifo_lvl = 8'h33;
    coll_pos = 8'h5a;
    fifo_we = 1'b1;
    coll_we = 1'b1;
    cyc(1);
    fifo_we = 1'b0;
    coll_we = 1'b0;
    wr(ADR_FSTAT, 8'hff);
    rdr(ADR_FSTAT, got);
    chk8("fifo status", 8'h33, got);
    rdr(ADR_COLL, got);
    chk8("collision", 8'h5a, got);
    cmd(CMD_RESET);
    rdr(ADR_FSTAT, got);
    chk8("fifo status", ZERO_BYTE, got);
    rdr(ADR_COLL, got);
    chk8("collision", ZERO_BYTE, got);
    cmd(CMD_INIT);
    chk8("modulator", MODC_RST, modc);
    // Receiver block and its two releases
    cmd(CMD_RXBLK);
    chk1("rx block", 1'b1, rx_blk);
    tx_done = 1'b1;
    cyc(1);
    tx_done = 1'b0;
    cyc(3);
    chk1("rx block", 1'b0, rx_blk);
    cmd(CMD_RXBLK);
    cmd(CMD_RXEN);
    chk1("rx block", 1'b0, rx_blk);
    // Direct mode 0 entered right after a transmit command
    wr(ADR_MODC, 8'h61);
    irq_req = 1'b1;
    cyc(2);
    chk1("irq", 1'b1, irq);
    host.open_frame();
    host.xfer(8'h90, rd);
    host.xfer(8'h00, rd);
    host.xfer(8'h40, rd);
    cyc(8);
    chk1("direct", 1'b1, dir_act);
    chk8("chip status", 8'h40, csc);
    chk1("fifo enable", 1'b0, fifo_en);
    chk1("irq", 1'b0, irq);
    // Host codes its own frame on the pin
    mod_pin = 1'b1;
    sub_pin = 1'b1;
    cyc(5);
    chk1("rf mod", 1'b1, rf_mod);
    chk1("rx data", 1'b1, rx_data);
    mod_pin = 1'b0;
    sub_pin = 1'b0;
    cyc(5);
    chk1("rf mod", 1'b0, rf_mod);
    chk1("rx data", 1'b0, rx_data);
    clr_seen = 1'b1;
    cyc(1);
    clr_seen = 1'b0;
    host.xfer(8'h09, rd);
    host.xfer(8'h00, rd);
    host.xfer(8'h8f, rd);
    cyc(8);
    chk8("strobes", 8'h00, seen);
    chk8("modulator", 8'h61, modc);
    mod_pin = 1'b1;
    host.close_frame();
    cyc(8);
    chk1("direct", 1'b0, dir_act);
    chk8("chip status", CSC_RST, csc);
    chk1("fifo enable", 1'b1, fifo_en);
    chk1("irq", 1'b1, irq);
    chk1("rf mod", 1'b0, rf_mod);
    // Variant one keeps registers open and shows decoded data
    wr(ADR_PROT, 8'h42);
    host.open_frame();
    host.xfer(8'h00, rd);
    host.xfer(8'h40, rd);
    cyc(8);
    chk1("direct", 1'b1, dir_act);
    dec_pin = 1'b1;
    cyc(3);
    chk1("rx data", 1'b1, rx_data);
    host.xfer(8'h09, rd);
    host.xfer(8'h21, rd);
    cyc(8);
    chk8("modulator", 8'h21, modc);
    host.close_frame();
    cyc(8);
    chk1("direct", 1'b0, dir_act);
    close_out();
  end
endmodule
